// ===== logic/scbg_defines.svh
/*
 * Constants of the coherency and maintenance broadcast gate.
 * Assumes inclusion by the package and the design modules only.
 */
`ifndef SCBG_DEFINES_SVH
`define SCBG_DEFINES_SVH

// ------------------------------------------------------------------
// Field widths and peer count
// ------------------------------------------------------------------
`define SCBG_CODE_W 4
`define SCBG_ARG_W 32
`define SCBG_N_PEERS 3

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define SCBG_RST_FLAG 1'b0
`define SCBG_RST_CODE 4'h0
`define SCBG_RST_ARG 32'h0000_0000

`endif

// ===== logic/scbg_pkg.sv
/*
 * Types shared by the coherency gate modules.
 * Assumes scbg_defines.svh is on the include path.
 */
`include "scbg_defines.svh"

package scbg_pkg;

  typedef enum logic [1:0] {
    SCBG_MEM_NORMAL,
    SCBG_MEM_DEVICE,
    SCBG_MEM_STRONG
  } scbg_mem_type_t;

  typedef enum logic {
    SCBG_MAINT_TLB,
    SCBG_MAINT_CACHE
  } scbg_maint_kind_t;

  typedef struct packed {
    scbg_maint_kind_t kind;
    logic [`SCBG_CODE_W-1:0] code;
    logic [`SCBG_ARG_W-1:0] arg;
  } scbg_maint_t;

endpackage

// ===== logic/scbg_attr_if.sv
/*
 * Carrier between the gate top and its attribute classifier.
 * Assumes both ends run combinationally on the same cycle.
 */
interface scbg_attr_if;
  import scbg_pkg::*;

  scbg_mem_type_t mem_type;
  logic shareable;
  logic write_back;
  logic cacheable_attr;
  logic coherent_mode;
  logic coherent;
  logic cacheable;

  modport requester (
    output mem_type,
    output shareable,
    output write_back,
    output cacheable_attr,
    output coherent_mode,
    input coherent,
    input cacheable
  );

  modport classifier (
    input mem_type,
    input shareable,
    input write_back,
    input cacheable_attr,
    input coherent_mode,
    output coherent,
    output cacheable
  );
endinterface

// ===== logic/scbg_attr_classify.sv
/*
 * Decides coherency and cacheability of one access from its attributes.
 * Assumes attributes arrive already decoded from the translation walk.
 */
module scbg_attr_classify (
  scbg_attr_if.classifier a
);
  import scbg_pkg::*;

  logic wb_normal;

  always_comb begin
    wb_normal = (a.mem_type == SCBG_MEM_NORMAL) && a.write_back;
    // Snooping only for write-back shareable normal in coherent mode
    a.coherent = a.coherent_mode && wb_normal && a.shareable;
    // Shareable but not write-back normal falls back to uncached
    a.cacheable = (a.mem_type == SCBG_MEM_NORMAL) && a.cacheable_attr
                  && !(a.shareable && !wb_normal);
  end
endmodule

// ===== logic/scbg_gate.sv
/*
 * Per-core gate deciding coherency participation and the flow of
 * cache and TLB maintenance operations to and from peer cores.
 * Assumes peers, the core pipeline and the local maintenance engine all
 * run on clk; the auxiliary control bits are levels from core logic.
 */
// Functional notes
// - L1 data coherency applies only while this core's coherent mode enable is set.
// - Only write-back, shareable, normal accesses are kept coherent.
// - Shareable memory that is not write-back normal is treated as non-cacheable.
// - Broadcastable maintenance goes to peers only when both enable bits are 1.
// - Peer maintenance is executed only while coherent mode is 1; otherwise it is accepted and dropped.
// - TLB and cache operations are both broadcast, only among coherent-mode cores.
// - Coherency follows a weakly ordered model, not a sequentially consistent one.
`include "scbg_defines.svh"
module scbg_gate #(
  parameter int N_PEERS = `SCBG_N_PEERS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic coherent_mode_enable,
  input wire logic maint_broadcast_enable,
  input wire logic acc_valid,
  input wire scbg_pkg::scbg_mem_type_t acc_mem_type,
  input wire logic acc_shareable,
  input wire logic acc_write_back,
  input wire logic acc_cacheable,
  output logic res_valid,
  output logic res_coherent,
  output logic res_cacheable,
  input wire logic own_valid,
  output logic own_ready,
  input wire logic own_broadcastable,
  input wire scbg_pkg::scbg_maint_t own_op,
  output logic bc_valid,
  input wire logic bc_ready,
  output scbg_pkg::scbg_maint_t bc_op,
  input wire logic [N_PEERS-1:0] peer_valid,
  output logic [N_PEERS-1:0] peer_ready,
  input wire scbg_pkg::scbg_maint_t peer_op [N_PEERS],
  output logic exec_valid,
  input wire logic exec_ready,
  output scbg_pkg::scbg_maint_t exec_op,
  output logic exec_from_peer
);
  import scbg_pkg::*;

  // ------------------------------------------------------------------
  // Access classification
  // ------------------------------------------------------------------
  scbg_attr_if attr ();

  assign attr.mem_type = acc_mem_type;
  assign attr.shareable = acc_shareable;
  assign attr.write_back = acc_write_back;
  assign attr.cacheable_attr = acc_cacheable;
  assign attr.coherent_mode = coherent_mode_enable;

  scbg_attr_classify u_classify (
    .a (attr.classifier)
  );

  logic res_valid_reg, res_valid_next;
  logic res_coherent_reg, res_coherent_next;
  logic res_cacheable_reg, res_cacheable_next;

  always_comb begin
    res_valid_next = acc_valid;
    res_coherent_next = res_coherent_reg;
    res_cacheable_next = res_cacheable_reg;
    if (acc_valid) begin
      res_coherent_next = attr.coherent;
      res_cacheable_next = attr.cacheable;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      res_valid_reg <= `SCBG_RST_FLAG;
      res_coherent_reg <= `SCBG_RST_FLAG;
      res_cacheable_reg <= `SCBG_RST_FLAG;
    end else begin
      res_valid_reg <= res_valid_next;
      res_coherent_reg <= res_coherent_next;
      res_cacheable_reg <= res_cacheable_next;
    end
  end

  assign res_valid = res_valid_reg;
  assign res_coherent = res_coherent_reg;
  assign res_cacheable = res_cacheable_reg;

  // ------------------------------------------------------------------
  // Peer request selection
  // ------------------------------------------------------------------
  // Fixed priority, lowest index first; peers are expected to hold
  // their request, so a low index can starve a high one under load.
  logic [N_PEERS-1:0] peer_first;
  logic [N_PEERS:0] peer_seen;
  logic exec_valid_reg, exec_valid_next;
  logic bc_valid_reg, bc_valid_next;
  logic exec_free;

  assign peer_seen[0] = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < N_PEERS; gi++) begin : g_peer
      assign peer_first[gi] = peer_valid[gi] && !peer_seen[gi];
      assign peer_seen[gi+1] = peer_seen[gi] || peer_valid[gi];
      // Out of coherent mode peer traffic is consumed and discarded,
      // so a peer never stalls on a core that has left the domain.
      assign peer_ready[gi] = coherent_mode_enable ? (peer_first[gi] && exec_free)
                              : 1'b1;
    end
  endgenerate

  logic peer_any;
  scbg_maint_t peer_sel_op;

  assign peer_any = peer_seen[N_PEERS];

  always_comb begin
    peer_sel_op = peer_op[0];
    for (int i = N_PEERS - 1; i >= 0; i--) begin
      if (peer_first[i]) begin
        peer_sel_op = peer_op[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // Maintenance flow control
  // ------------------------------------------------------------------
  logic bc_free;
  logic bcast_en;
  logic own_bcast;
  logic peer_take;
  logic own_take;

  assign exec_free = !exec_valid_reg || exec_ready;
  assign bc_free = !bc_valid_reg || bc_ready;
  assign bcast_en = coherent_mode_enable && maint_broadcast_enable;
  assign own_bcast = own_broadcastable && bcast_en;
  assign peer_take = peer_any && coherent_mode_enable && exec_free;

  // Own request waits for the broadcast slot only when it will use it,
  // so a non-broadcast op is never held up by slow peers.
  assign own_ready = exec_free && !(peer_any && coherent_mode_enable)
                     && (!own_bcast || bc_free);
  assign own_take = own_valid && own_ready;

  // ------------------------------------------------------------------
  // Local execution slot
  // ------------------------------------------------------------------
  logic exec_from_peer_reg, exec_from_peer_next;
  scbg_maint_t exec_op_reg, exec_op_next;

  always_comb begin
    exec_valid_next = exec_valid_reg;
    exec_from_peer_next = exec_from_peer_reg;
    exec_op_next = exec_op_reg;
    if (exec_valid_reg && exec_ready) begin
      exec_valid_next = 1'b0;
    end
    if (peer_take) begin
      exec_valid_next = 1'b1;
      exec_from_peer_next = 1'b1;
      exec_op_next = peer_sel_op;
    end else if (own_take) begin
      // Always done locally, broadcast or not
      exec_valid_next = 1'b1;
      exec_from_peer_next = 1'b0;
      exec_op_next = own_op;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      exec_valid_reg <= `SCBG_RST_FLAG;
      exec_from_peer_reg <= `SCBG_RST_FLAG;
      exec_op_reg <= '{SCBG_MAINT_TLB, `SCBG_RST_CODE, `SCBG_RST_ARG};
    end else begin
      exec_valid_reg <= exec_valid_next;
      exec_from_peer_reg <= exec_from_peer_next;
      exec_op_reg <= exec_op_next;
    end
  end

  assign exec_valid = exec_valid_reg;
  assign exec_from_peer = exec_from_peer_reg;
  assign exec_op = exec_op_reg;

  // ------------------------------------------------------------------
  // Broadcast slot
  // ------------------------------------------------------------------
  // Local execution and broadcast drain independently: no wait for
  // peer completion, matching weak ordering; software barriers order.
  scbg_maint_t bc_op_reg, bc_op_next;

  always_comb begin
    bc_valid_next = bc_valid_reg;
    bc_op_next = bc_op_reg;
    if (bc_valid_reg && bc_ready) begin
      bc_valid_next = 1'b0;
    end
    if (own_take && own_bcast) begin
      bc_valid_next = 1'b1;
      bc_op_next = own_op;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bc_valid_reg <= `SCBG_RST_FLAG;
      bc_op_reg <= '{SCBG_MAINT_TLB, `SCBG_RST_CODE, `SCBG_RST_ARG};
    end else begin
      bc_valid_reg <= bc_valid_next;
      bc_op_reg <= bc_op_next;
    end
  end

  assign bc_valid = bc_valid_reg;
  assign bc_op = bc_op_reg;

endmodule

// ===== tb/scbg_gate_properties.sv
/* Port checker for the coherency gate.
   Assumes a bind to scbg_gate and a single clock. */
module scbg_gate_props #(parameter int N_PEERS = 3) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic coherent_mode_enable,
  input wire logic maint_broadcast_enable,
  input wire logic acc_valid,
  input wire scbg_pkg::scbg_mem_type_t acc_mem_type,
  input wire logic acc_shareable,
  input wire logic acc_write_back,
  input wire logic res_valid,
  input wire logic res_coherent,
  input wire logic res_cacheable,
  input wire logic own_valid,
  input wire logic own_ready,
  input wire logic own_broadcastable,
  input wire scbg_pkg::scbg_maint_t own_op,
  input wire logic bc_valid,
  input wire scbg_pkg::scbg_maint_t bc_op,
  input wire logic [N_PEERS-1:0] peer_valid,
  input wire logic [N_PEERS-1:0] peer_ready,
  input wire logic exec_valid,
  input wire scbg_pkg::scbg_maint_t exec_op,
  input wire logic exec_from_peer
);
  timeunit 1ns;
  timeprecision 1ps;
  import scbg_pkg::*;
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic take = own_valid && own_ready;
  wire logic bcast = own_broadcastable && coherent_mode_enable && maint_broadcast_enable;
  wire logic wbn = acc_mem_type == SCBG_MEM_NORMAL && acc_write_back;
  property p_res; acc_valid |=> res_valid &&
    res_coherent == $past(coherent_mode_enable && wbn && acc_shareable); endproperty
  a_res: assert property (p_res) else $error("coherent flag wrong");
  property p_nc; acc_valid && acc_shareable && !wbn |=> !res_cacheable; endproperty
  a_nc: assert property (p_nc) else $error("shareable line cached");
  property p_bc; take && bcast |=> bc_valid && bc_op == $past(own_op); endproperty
  a_bc: assert property (p_bc) else $error("broadcast missing");
  property p_nobc; $rose(bc_valid) |-> $past(take && bcast); endproperty
  a_nobc: assert property (p_nobc) else $error("broadcast not allowed");
  property p_own; take |=> exec_valid && !exec_from_peer && exec_op == $past(own_op);
  endproperty
  a_own: assert property (p_own) else $error("own op not run locally");
  property p_drop; !coherent_mode_enable |-> &peer_ready; endproperty
  a_drop: assert property (p_drop) else $error("peer stalled");
  property p_peer; coherent_mode_enable && peer_valid[0] && peer_ready[0] |=>
    exec_valid && exec_from_peer; endproperty
  a_peer: assert property (p_peer) else $error("peer op not run");
  property p_pexec; $rose(exec_from_peer) |-> $past(coherent_mode_enable); endproperty
  a_pexec: assert property (p_pexec) else $error("peer op run off mode");
endmodule

// ===== tb/scbg_peer_model.sv
/* Peer cores of the coherent domain.
   Assumes the core clock; the bench calls send. */
module scbg_peer_model #(parameter int N_PEERS = 3) (
  input wire logic clk,
  input wire logic slow,
  input wire logic bc_valid,
  input wire scbg_pkg::scbg_maint_t bc_op,
  output logic bc_ready,
  input wire logic [N_PEERS-1:0] peer_ready,
  output logic [N_PEERS-1:0] peer_valid,
  output scbg_pkg::scbg_maint_t peer_op [N_PEERS]
);
  timeunit 1ns;
  timeprecision 1ps;
  import scbg_pkg::*;
  initial begin
    bc_ready = 1'b0;
    peer_valid = '0;
    foreach (peer_op[i]) peer_op[i] = '0;
  end
  // Busy peers hold off the broadcast at random
  always @(negedge clk) bc_ready <= slow ? 1'($urandom) : 1'b1;
  task automatic send(input int i, input scbg_maint_t op);
    @(negedge clk);
    peer_valid[i] = 1'b1;
    peer_op[i] = op;
    #1;
    while (!peer_ready[i]) begin
      @(negedge clk);
      #1;
    end
    @(negedge clk);
    peer_valid[i] = 1'b0;
    peer_op[i] = ~op; // Released payload goes stale
  endtask
endmodule

// ===== tb/scbg_gate_test.sv
/* Self-checking bench of the coherency gate.
   Assumes package, gate, checker and peer model compiled first. */
bind scbg_gate scbg_gate_props #(.N_PEERS(N_PEERS)) scbg_gate_props_i (.*);
module scbg_gate_test;
  timeunit 1ns;
  timeprecision 1ps;
  import scbg_pkg::*;
  localparam int N_PEERS = 3;
  logic clk, resetn, coherent_mode_enable, maint_broadcast_enable, acc_valid, nrm;
  logic acc_shareable, acc_write_back, acc_cacheable, res_valid, res_coherent;
  logic res_cacheable, own_valid, own_ready, own_broadcastable, bc_valid, bc_ready;
  logic exec_valid, exec_from_peer, slow;
  logic exec_ready = 1'b0;
  scbg_mem_type_t acc_mem_type;
  scbg_maint_t own_op, bc_op, exec_op, op;
  scbg_maint_t peer_op [N_PEERS];
  logic [N_PEERS-1:0] peer_valid, peer_ready;
  int errors, check_count;
  logic [37:0] ex_q [$];
  scbg_maint_t bc_q [$];
  logic [1:0] res_q [$];
  scbg_gate #(.N_PEERS(N_PEERS)) scbg_gate_i (.*);
  scbg_peer_model #(.N_PEERS(N_PEERS)) scbg_peer_model_i (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [37:0] got, input logic [37:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic own_req(input logic b, input scbg_maint_t o);
    own_valid = 1'b1;
    own_broadcastable = b;
    own_op = o;
    #1;
    while (!own_ready) begin
      @(negedge clk);
      #1;
    end
    ex_q.push_back({1'b0, o});
    if (b && coherent_mode_enable && maint_broadcast_enable) bc_q.push_back(o);
    @(negedge clk);
  endtask
  // ----
  // Result monitors
  // ----
  always @(negedge clk) exec_ready <= 2'($urandom) != 2'h0;
  always @(posedge clk) begin
    if (resetn && res_valid) chk(38'({res_coherent, res_cacheable}),
      res_q.size() ? 38'(res_q.pop_front()) : 'x);
    if (resetn && exec_valid && exec_ready) chk({exec_from_peer, exec_op},
      ex_q.size() ? ex_q.pop_front() : 'x);
    if (resetn && bc_valid && bc_ready) chk(38'(bc_op),
      bc_q.size() ? 38'(bc_q.pop_front()) : 'x);
  end
  initial begin
    #200000;
    errors++;
    complete_run();
  end
  // ----
  // Tests
  // ----
  initial begin
    {resetn, coherent_mode_enable, maint_broadcast_enable, acc_valid, slow} = '0;
    {acc_shareable, acc_write_back, acc_cacheable, own_valid, own_broadcastable} = '0;
    acc_mem_type = SCBG_MEM_NORMAL;
    own_op = '0;
    void'($urandom(32'hef96));
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    for (int i = 0; i < 80; i++) begin
      @(negedge clk);
      coherent_mode_enable = 1'($urandom);
      acc_valid = 1'($urandom);
      acc_mem_type = scbg_mem_type_t'($urandom % 3);
      {acc_shareable, acc_write_back, acc_cacheable} = 3'($urandom);
      nrm = acc_mem_type == SCBG_MEM_NORMAL;
      if (acc_valid) res_q.push_back({coherent_mode_enable & nrm & acc_write_back &
        acc_shareable, nrm & acc_cacheable & !(acc_shareable & !acc_write_back)});
    end
    @(negedge clk);
    acc_valid = 1'b0;
    $display("access test done");
    slow = 1'b1;
    for (int i = 0; i < 16; i++) begin
      coherent_mode_enable = i[2];
      maint_broadcast_enable = i[3];
      own_req(i[1], {scbg_maint_kind_t'(i[0]), 4'(i), 32'($urandom)});
    end
    own_valid = 1'b0;
    $display("own test done");
    for (int i = 0; i < 6; i++) begin
      coherent_mode_enable = i < 3;
      maint_broadcast_enable = i[0];
      op = {scbg_maint_kind_t'(i[0]), 4'(i), 32'($urandom)};
      if (i < 3) ex_q.push_back({1'b1, op});
      scbg_peer_model_i.send(i % 3, op);
    end
    coherent_mode_enable = 1'b1;
    // Two peers at once: lowest index goes first
    ex_q.push_back({1'b1, op});
    ex_q.push_back({1'b1, ~op});
    fork
      scbg_peer_model_i.send(1, ~op);
      scbg_peer_model_i.send(0, op);
    join
    ex_q.push_back({1'b1, op});
    fork
      scbg_peer_model_i.send(2, op);
      begin
        @(negedge clk);
        own_req(1'b0, ~op);
      end
    join
    own_valid = 1'b0;
    for (int i = 0; i < 300 && ex_q.size() + bc_q.size() > 0; i++) @(negedge clk);
    chk(38'(ex_q.size() + bc_q.size() + res_q.size()), 38'h0);
    $display("peer test done");
    complete_run();
  end
endmodule
